// File: design/ipr_pkg.sv
// Package for the 64-source interrupt prioritizer.
// Holds the configuration select codes, the reset values and the field sizes.
// Everything that uses it names package::item; nothing imports it.
package ipr_pkg;

  // Largest number of request lines and the width of a source number.
  localparam int MAX_SRC = 64;
  localparam int SRC_W = 6;
  localparam int LVL_W = 4;
  localparam int NUM_LVL_REGS = 8;
  localparam int LVL_PER_REG = 8;

  // Configuration select codes for the plain write/read port.
  localparam logic [3:0] SEL_EN_LO = 4'h0;
  localparam logic [3:0] SEL_EN_HI = 4'h1;
  localparam logic [3:0] SEL_EN_NUM = 4'h2;
  localparam logic [3:0] SEL_DIS_NUM = 4'h3;
  localparam logic [3:0] SEL_TYPE_LO = 4'h4;
  localparam logic [3:0] SEL_TYPE_HI = 4'h5;
  localparam logic [3:0] SEL_MASK = 4'h6;
  localparam logic [3:0] SEL_STATUS = 4'h7;
  localparam logic [3:0] SEL_LVL0 = 4'h8;

  // Mask field: bit 4 set turns level masking off.
  localparam int MASK_W = 5;
  localparam int MASK_OFF_BIT = 4;
  localparam logic [4:0] MASK_RST = 5'h10;

  // Values after reset of the other configuration state.
  localparam logic [63:0] ENABLE_RST = 64'h0000000000000000;
  localparam logic [63:0] TYPE_RST = 64'h0000000000000000;
  localparam logic [255:0] LEVEL_RST = 256'h0;

  // Status word field positions.
  localparam int ST_NORM_SRC = 0;
  localparam int ST_FAST_SRC = 8;
  localparam int ST_NORM_VLD = 16;
  localparam int ST_FAST_VLD = 17;

endpackage : ipr_pkg

// File: design/ipr_rank_if.sv
// Carrier between the prioritizer core and its ranking stage.
// Assumes both ends sit on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface ipr_rank_if;
  logic [63:0] pend_norm;
  logic [63:0] pend_fast;
  logic [255:0] level;
  logic norm_valid;
  logic [5:0] norm_src;
  logic fast_valid;
  logic [5:0] fast_src;

  // The core offers pending vectors and levels and reads back the winners.
  modport core (
    output pend_norm,
    output pend_fast,
    output level,
    input norm_valid,
    input norm_src,
    input fast_valid,
    input fast_src
  );

  modport rank (
    input pend_norm,
    input pend_fast,
    input level,
    output norm_valid,
    output norm_src,
    output fast_valid,
    output fast_src
  );
endinterface : ipr_rank_if
`default_nettype wire

// File: design/ipr_rank.sv
// Ranking stage: picks the winning fast and normal source each cycle.
// Assumes pending vectors are already gated by enable, type and mask.
`timescale 1ns/100ps
`default_nettype none
module ipr_rank (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  ipr_rank_if.rank rk
);

  // Highest level wins; the ascending scan with >= lets a higher source
  // number take a tie on the same level.
  function automatic logic [6:0] best_norm(input logic [63:0] pend,
                                           input logic [255:0] lvl);
    logic found;
    logic [5:0] src;
    logic [3:0] top;
    found = 1'b0;
    src = 6'h00;
    top = 4'h0;
    for (int i = 0; i < ipr_pkg::MAX_SRC; i++) begin
      if (pend[i] && (!found || lvl[i*4 +: 4] >= top)) begin
        found = 1'b1;
        src = 6'(i);
        top = lvl[i*4 +: 4];
      end
    end
    return {found, src};
  endfunction : best_norm

  // Among fast sources the highest number wins.
  function automatic logic [6:0] best_fast(input logic [63:0] pend);
    logic found;
    logic [5:0] src;
    found = 1'b0;
    src = 6'h00;
    for (int i = 0; i < ipr_pkg::MAX_SRC; i++) begin
      if (pend[i]) begin
        found = 1'b1;
        src = 6'(i);
      end
    end
    return {found, src};
  endfunction : best_fast

  logic [6:0] norm_pick;
  logic [6:0] fast_pick;

  // Winner selection over the whole pending set.
  always_comb begin
    norm_pick = best_norm(rk.pend_norm, rk.level);
    fast_pick = best_fast(rk.pend_fast);
  end

  // Results are registered so the core outputs come from flip-flops.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rk.norm_valid <= 1'b0;
      rk.norm_src <= 6'h00;
      rk.fast_valid <= 1'b0;
      rk.fast_src <= 6'h00;
    end else if (ce_in) begin
      rk.norm_valid <= norm_pick[6];
      rk.norm_src <= norm_pick[5:0];
      rk.fast_valid <= fast_pick[6];
      rk.fast_src <= fast_pick[5:0];
    end
  end

endmodule : ipr_rank
`default_nettype wire

// File: design/ipr_core.sv
// Top of the interrupt prioritizer: request capture, configuration state,
// gating and the normal/fast request outputs toward the core.
// Assumes request lines may be asynchronous and that the privilege flag
// travels with every configuration access.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Accept up to sixty-four request lines.
// - Per-source enable, bitmap or set/clear numbers.
// - Enabled asserted source raises normal or fast.
// - Configuration access only with supervisor privilege.
// - Fast first, then level, then number.
// - Sixteen normal levels, zero ranks lowest.
// - Eight writable level registers cover sources.
// - Mask register suppresses normal requests by level.
module ipr_core #(
  parameter int NSRC = 64
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [NSRC-1:0] src_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_super_in,
  input wire logic [3:0] cfg_sel_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  output logic cfg_err_out,
  output logic norm_req_out,
  output logic [5:0] norm_src_out,
  output logic fast_req_out,
  output logic [5:0] fast_src_out
);

  // Sources are grouped eight to a level register, so only multiples of eight.
  generate
    if (NSRC < 8 || NSRC > ipr_pkg::MAX_SRC || (NSRC % 8) != 0) begin : g_chk
      $error("NSRC must be a multiple of 8 between 8 and 64");
    end
  endgenerate

  // The ranking stage and the level bank are built for six-bit source
  // numbers and four-bit levels; other package sizes would misalign them.
  generate
    if (ipr_pkg::SRC_W != 6 || ipr_pkg::LVL_W != 4) begin : g_chk_w
      $error("source number and level widths must be 6 and 4");
    end
  endgenerate

  // Request capture and filter stages.
  logic [NSRC-1:0] sync1_r;
  logic [NSRC-1:0] sync2_r;
  logic [NSRC-1:0] sync3_r;
  logic [NSRC-1:0] filt_r;
  logic [63:0] src_all;
  // Configuration state, always held for the full 64 sources.
  logic [63:0] enable_r;
  logic [63:0] type_r;
  logic [255:0] level_r;
  logic [4:0] mask_r;
  // Gated request vectors and access decode.
  logic [63:0] active;
  logic [63:0] lvl_block;
  logic acc_ok;
  logic wr_ok;
  logic [3:0] lvl_idx;
  logic [31:0] rd_word;

  ipr_rank_if rk_if ();

  // Level index within the bank of level registers. Only its low three
  // bits are used, so codes 8 to 15 reach the bank and nothing else does.
  // Privilege travels with each strobe; a user-mode access is refused here.
  assign lvl_idx = cfg_sel_in - ipr_pkg::SEL_LVL0;
  assign acc_ok = cfg_super_in;
  assign wr_ok = cfg_wr_in && acc_ok;

  // Three-stage capture of the request lines; a change is taken only when
  // the last two stages agree, which rejects single-cycle glitches.
  // A request not sampled on two edges in a row is never seen, so sources must hold
  // their line until software has serviced them.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r <= '0;
    end else if (ce_in) begin
      sync1_r <= src_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        filt_r <= sync3_r;
      end
    end
  end

  // Unbuilt upper lines read as idle when fewer than 64 sources exist.
  assign src_all = 64'(filt_r);

  // Enable bitmap: whole halves or a single bit by source number.
  // A set and a clear by number cannot meet, as one select picks one target.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enable_r <= ipr_pkg::ENABLE_RST;
    end else if (ce_in && wr_ok) begin
      if (cfg_sel_in == ipr_pkg::SEL_EN_LO) begin
        enable_r[31:0] <= cfg_wdata_in;
      end else if (cfg_sel_in == ipr_pkg::SEL_EN_HI) begin
        enable_r[63:32] <= cfg_wdata_in;
      end else if (cfg_sel_in == ipr_pkg::SEL_EN_NUM) begin
        enable_r[cfg_wdata_in[5:0]] <= 1'b1;
      end else if (cfg_sel_in == ipr_pkg::SEL_DIS_NUM) begin
        enable_r[cfg_wdata_in[5:0]] <= 1'b0;
      end
    end
  end

  // Per-source type: a set bit routes the source to the fast request.
  // A type change while the source is pending moves it at once.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      type_r <= ipr_pkg::TYPE_RST;
    end else if (ce_in && wr_ok) begin
      if (cfg_sel_in == ipr_pkg::SEL_TYPE_LO) begin
        type_r[31:0] <= cfg_wdata_in;
      end else if (cfg_sel_in == ipr_pkg::SEL_TYPE_HI) begin
        type_r[63:32] <= cfg_wdata_in;
      end
    end
  end

  // Level bank: register k holds sources 8k..8k+7, four bits each,
  // lowest source in the lowest nibble.
  // A write to one register leaves the other seven untouched.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_r <= ipr_pkg::LEVEL_RST;
    end else if (ce_in && wr_ok && cfg_sel_in >= ipr_pkg::SEL_LVL0) begin
      level_r[lvl_idx[2:0]*32 +: 32] <= cfg_wdata_in;
    end
  end

  // Mask register; reset sets the off bit so no level is blocked.
  // A new mask reaches the request outputs two edges after its write.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mask_r <= ipr_pkg::MASK_RST;
    end else if (ce_in && wr_ok && cfg_sel_in == ipr_pkg::SEL_MASK) begin
      mask_r <= cfg_wdata_in[4:0];
    end
  end

  // Gating: a source counts only while enabled and asserted, then splits
  // by type; normal sources at or below the mask level are held back.
  always_comb begin
    lvl_block = '0;
    for (int i = 0; i < ipr_pkg::MAX_SRC; i++) begin
      lvl_block[i] = !mask_r[ipr_pkg::MASK_OFF_BIT] &&
                     (level_r[i*4 +: 4] <= mask_r[3:0]);
    end
  end

  // Fast sources ignore the mask, which only blocks normal levels.
  assign active = src_all & enable_r;
  assign rk_if.pend_fast = active & type_r;
  assign rk_if.pend_norm = active & ~type_r & ~lvl_block;
  assign rk_if.level = level_r;

  // Ranking stage; its registered winners feed the request outputs.
  ipr_rank u_rank (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .rk(rk_if.rank)
  );

  // Request outputs follow the registered ranking results directly.
  assign norm_req_out = rk_if.norm_valid;
  assign norm_src_out = rk_if.norm_src;
  assign fast_req_out = rk_if.fast_valid;
  assign fast_src_out = rk_if.fast_src;

  // Read selection; number registers are write-only and read as zero.
  // Writes to the status select are dropped, as nothing decodes them.
  always_comb begin
    rd_word = 32'h00000000;
    unique case (cfg_sel_in)
      ipr_pkg::SEL_EN_LO: rd_word = enable_r[31:0];
      ipr_pkg::SEL_EN_HI: rd_word = enable_r[63:32];
      ipr_pkg::SEL_TYPE_LO: rd_word = type_r[31:0];
      ipr_pkg::SEL_TYPE_HI: rd_word = type_r[63:32];
      ipr_pkg::SEL_MASK: rd_word = 32'(mask_r);
      ipr_pkg::SEL_STATUS: begin
        rd_word[ipr_pkg::ST_NORM_SRC +: 6] = rk_if.norm_src;
        rd_word[ipr_pkg::ST_FAST_SRC +: 6] = rk_if.fast_src;
        rd_word[ipr_pkg::ST_NORM_VLD] = rk_if.norm_valid;
        rd_word[ipr_pkg::ST_FAST_VLD] = rk_if.fast_valid;
      end
      ipr_pkg::SEL_EN_NUM, ipr_pkg::SEL_DIS_NUM: rd_word = 32'h00000000;
      default: rd_word = level_r[lvl_idx[2:0]*32 +: 32];
    endcase
  end

  // Read answer one cycle later; a user-mode access gets no data and
  // an error pulse instead, and a user-mode write changes nothing.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_rdata_out <= 32'h00000000;
      cfg_rvalid_out <= 1'b0;
      cfg_err_out <= 1'b0;
    end else if (ce_in) begin
      cfg_rvalid_out <= cfg_rd_in && acc_ok;
      cfg_err_out <= (cfg_rd_in || cfg_wr_in) && !acc_ok;
      cfg_rdata_out <= (cfg_rd_in && acc_ok) ? rd_word : 32'h00000000;
    end
  end

endmodule : ipr_core
`default_nettype wire

// File: verification/ipr_core_props.sv
// Port-level checks on the interrupt prioritizer.
// Assumes one clock domain and no strobe around a drop of ce_in.
`timescale 1ns/100ps
`default_nettype none
module ipr_core_props #(
  parameter int NSRC = 64
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [NSRC-1:0] src_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_super_in,
  input wire logic [3:0] cfg_sel_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_rvalid_out,
  input wire logic cfg_err_out,
  input wire logic norm_req_out,
  input wire logic [5:0] norm_src_out,
  input wire logic fast_req_out,
  input wire logic [5:0] fast_src_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // A strobe without privilege must be refused.
  sequence s_refused;
    ce_in && (cfg_wr_in || cfg_rd_in) && !cfg_super_in;
  endsequence
  sequence s_rd_ok;
    ce_in && cfg_rd_in && cfg_super_in && !cfg_wr_in;
  endsequence
  // Eight quiet samples flush the sync and filter stages.
  sequence s_quiet;
    (src_in == '0) [*8];
  endsequence
  // A privileged read of the status word.
  sequence s_status_rd;
    ce_in && cfg_rd_in && cfg_super_in && !cfg_wr_in &&
      cfg_sel_in == ipr_pkg::SEL_STATUS;
  endsequence
  AST_REFUSE_ERR: assert property (s_refused |=> cfg_err_out)
    else $error("refused access gave no error pulse");
  AST_REFUSE_NODATA: assert property (
    s_refused |=> !cfg_rvalid_out && cfg_rdata_out == 32'h0)
    else $error("refused access returned data");
  AST_ERR_CAUSE: assert property (
    cfg_err_out |->
      $past(ce_in && (cfg_wr_in || cfg_rd_in) && !cfg_super_in))
    else $error("error pulse without a refused access");
  AST_RD_ANSWER: assert property (
    s_rd_ok |=> cfg_rvalid_out && !cfg_err_out)
    else $error("privileged read not answered");
  AST_WR_SILENT: assert property (
    ce_in && cfg_wr_in && cfg_super_in && !cfg_rd_in |=>
      !cfg_rvalid_out && !cfg_err_out)
    else $error("privileged write gave an answer");
  AST_RDATA_IDLE: assert property (
    !cfg_rvalid_out |-> cfg_rdata_out == 32'h0)
    else $error("read data not zero outside an answer");
  AST_QUIET_NONE: assert property (
    s_quiet |-> !norm_req_out && !fast_req_out)
    else $error("request raised with no source asserted");
  AST_STATUS_RD: assert property (
    s_status_rd |=> cfg_rdata_out ==
      {14'h0, $past(fast_req_out), $past(norm_req_out), 2'h0,
      $past(fast_src_out), 2'h0, $past(norm_src_out)})
    else $error("status read does not match the request outputs");
endmodule : ipr_core_props
bind ipr_core ipr_core_props #(.NSRC(NSRC)) u_props (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .src_in(src_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
  .cfg_super_in(cfg_super_in), .cfg_sel_in(cfg_sel_in),
  .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
  .cfg_rvalid_out(cfg_rvalid_out), .cfg_err_out(cfg_err_out),
  .norm_req_out(norm_req_out), .norm_src_out(norm_src_out),
  .fast_req_out(fast_req_out), .fast_src_out(fast_src_out));
`default_nettype wire

// File: verification/ipr_cpu_model.sv
// Model of the processor core that takes both request levels.
// Assumes it shares the prioritizer's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module ipr_cpu_model (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic norm_req_in,
  input wire logic [5:0] norm_src_in,
  input wire logic fast_req_in,
  input wire logic [5:0] fast_src_in,
  output logic [5:0] norm_seen_out,
  output logic [5:0] fast_seen_out
);
  // The core keeps the last source of each exception kind it was asked for.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      norm_seen_out <= 6'h00;
      fast_seen_out <= 6'h00;
    end else begin
      if (norm_req_in)
        norm_seen_out <= norm_src_in;
      if (fast_req_in)
        fast_seen_out <= fast_src_in;
    end
  end
endmodule : ipr_cpu_model
`default_nettype wire

// File: verification/interrupt_prioritizer_64src_test.sv
// Bench: programs sources, then checks ranking, masking and refusal.
// Assumes the checker is bound in from its own file.
`timescale 1ns/100ps
`default_nettype none
module interrupt_prioritizer_64src_test;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic sup = 1'b1, rv, er, nr, fr;
  logic [1:0] e;
  logic [63:0] src = 64'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [5:0] ns, fs, pn, pf;
  int errors = 0, tests_run = 0;
  always #5 clk = ~clk;
  ipr_core #(.NSRC(64)) DUT (.sys_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
    .src_in(src), .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_super_in(sup),
    .cfg_sel_in(sel), .cfg_wdata_in(wd), .cfg_rdata_out(rdat),
    .cfg_rvalid_out(rv), .cfg_err_out(er), .norm_req_out(nr),
    .norm_src_out(ns), .fast_req_out(fr), .fast_src_out(fs));
  ipr_cpu_model CPU (.sys_clk_in(clk), .rstn_in(rstn), .norm_req_in(nr),
    .norm_src_in(ns), .fast_req_in(fr), .fast_src_in(fs),
    .norm_seen_out(pn), .fast_seen_out(pf));
  // Compare one word.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Compare both requests; a source counts only while its request is up.
  task automatic chk_req(input logic n, input logic [5:0] a,
      input logic f, input logic [5:0] b);
    tests_run++;
    if (nr !== n || fr !== f || (n && ns !== a) || (f && fs !== b)) begin
      errors++;
      $display("MISMATCH t=%0t req %b %h %b %h", $time, nr, ns, fr, fs);
    end
  endtask : chk_req
  // One access; the answer stands for one cycle, so it is taken a half
  // cycle after the edge that took the strobe, and a gap cycle follows.
  task automatic acc(input logic w, input logic [3:0] s,
      input logic [31:0] d, input logic p = 1'b1);
    wr = w;
    rd = !w;
    sel = s;
    wd = d;
    sup = p;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    q = rdat;
    e = {rv, er};
    @(negedge clk);
  endtask : acc
  // Sources need five edges to reach the outputs, writes two.
  task automatic settle;
    repeat (7) @(negedge clk);
  endtask : settle
  task automatic tally_and_finish;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    #50000;
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    acc(1'b0, ipr_pkg::SEL_MASK, 32'h0);
    chk(q, 32'h10);
    chk({30'h0, e}, 32'h2);
    // A refused write must leave the enables alone.
    acc(1'b1, ipr_pkg::SEL_EN_LO, 32'hFFFFFFFF, 1'b0);
    chk({30'h0, e}, 32'h1);
    acc(1'b0, ipr_pkg::SEL_EN_LO, 32'h0, 1'b0);
    chk(q, 32'h0);
    chk({30'h0, e}, 32'h1);
    acc(1'b0, ipr_pkg::SEL_EN_LO, 32'h0);
    chk(q, 32'h0);
    $display("test access done");
    // Sources 5 and 13 share level 3; 63 stays at level 0.
    acc(1'b1, ipr_pkg::SEL_EN_NUM, 32'h5);
    acc(1'b1, ipr_pkg::SEL_EN_NUM, 32'hD);
    acc(1'b1, ipr_pkg::SEL_EN_NUM, 32'h3F);
    acc(1'b1, 4'h8, 32'h00300000);
    acc(1'b1, 4'h9, 32'h00300000);
    src = 64'h8000000000002020;
    settle;
    chk_req(1'b1, 6'h0D, 1'b0, 6'h00);
    acc(1'b0, ipr_pkg::SEL_EN_LO, 32'h0);
    chk(q, 32'h00002020);
    acc(1'b1, 4'h8, 32'h00400000);
    settle;
    chk_req(1'b1, 6'h05, 1'b0, 6'h00);
    // Mask 3 keeps only level 4; mask 4 keeps nothing.
    acc(1'b1, ipr_pkg::SEL_MASK, 32'h3);
    settle;
    chk_req(1'b1, 6'h05, 1'b0, 6'h00);
    acc(1'b1, ipr_pkg::SEL_MASK, 32'h4);
    settle;
    chk_req(1'b0, 6'h00, 1'b0, 6'h00);
    acc(1'b1, ipr_pkg::SEL_MASK, 32'h10);
    // The top field of the last level register is source 63.
    acc(1'b1, 4'hF, 32'hF0000000);
    settle;
    chk_req(1'b1, 6'h3F, 1'b0, 6'h00);
    chk({26'h0, pn}, 32'h3F);
    $display("test level done");
    // Fast sources go out apart; the highest fast number wins.
    acc(1'b1, ipr_pkg::SEL_TYPE_LO, 32'h00002000);
    settle;
    chk_req(1'b1, 6'h3F, 1'b1, 6'h0D);
    acc(1'b1, ipr_pkg::SEL_TYPE_HI, 32'h80000000);
    settle;
    chk_req(1'b1, 6'h05, 1'b1, 6'h3F);
    acc(1'b1, ipr_pkg::SEL_DIS_NUM, 32'h3F);
    settle;
    chk_req(1'b1, 6'h05, 1'b1, 6'h0D);
    acc(1'b0, ipr_pkg::SEL_EN_HI, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, ipr_pkg::SEL_EN_HI, 32'h80000000);
    settle;
    chk_req(1'b1, 6'h05, 1'b1, 6'h3F);
    chk({26'h0, pf}, 32'h3F);
    // Status, type and level words read back as they stand.
    acc(1'b0, ipr_pkg::SEL_STATUS, 32'h0);
    chk(q, 32'h00033F05);
    acc(1'b0, ipr_pkg::SEL_TYPE_HI, 32'h0);
    chk(q, 32'h80000000);
    acc(1'b0, 4'h8, 32'h0);
    chk(q, 32'h00400000);
    acc(1'b0, 4'hF, 32'h0);
    chk(q, 32'hF0000000);
    // With the clock enable low a write is lost and the outputs hold.
    ce = 1'b0;
    acc(1'b1, ipr_pkg::SEL_DIS_NUM, 32'h5);
    settle;
    chk_req(1'b1, 6'h05, 1'b1, 6'h3F);
    ce = 1'b1;
    settle;
    chk_req(1'b1, 6'h05, 1'b1, 6'h3F);
    $display("test fast done");
    // A reset in mid-run drops both requests and every enable.
    rstn = 1'b0;
    @(negedge clk);
    chk_req(1'b0, 6'h00, 1'b0, 6'h00);
    rstn = 1'b1;
    settle;
    chk_req(1'b0, 6'h00, 1'b0, 6'h00);
    acc(1'b0, ipr_pkg::SEL_EN_LO, 32'h0);
    chk(q, 32'h0);
    acc(1'b0, ipr_pkg::SEL_MASK, 32'h0);
    chk(q, 32'h10);
    acc(1'b1, ipr_pkg::SEL_EN_NUM, 32'h5);
    settle;
    chk_req(1'b1, 6'h05, 1'b0, 6'h00);
    src = 64'h0;
    settle;
    chk_req(1'b0, 6'h00, 1'b0, 6'h00);
    $display("test reset done");
    tally_and_finish;
  end
endmodule : interrupt_prioritizer_64src_test
`default_nettype wire
